// File: rtl/swc_channel_ctrl.sv
// Switch input channel control: command decode, sources, analog select, status, interrupt
//
// How it works
// RULE1: high current only first 20 ms after closure
// RULE2: timer off means continuous wetting current
// RULE3: contact type picks 16 mA or 2 mA
// RULE4: analog command code picks one of 22 inputs
// RULE5: analog mux switches at select rising edge
// RULE6: analog-selected input reports status 0
// RULE7: analog input: hi-Z, 2 mA or 16 mA
// RULE8: reset gives Normal mode, all inputs tri-stated
// RULE9: battery type sinks, ground type sources
// RULE10: comparator active when tri-stated; low ground input reads 1
// RULE11: tri-state off enables source, on disables
// RULE12: interrupt enable per input
// RULE13: host orders gate driver setup commands
// RULE14: commands accepted in Normal mode
// RULE15: overheat forces 2 mA and interrupts
// RULE16: interrupt held low until status acknowledged
// RULE17: settings change only on complete frame
//
// Notes for users
// Every pin but the mode and reset inputs passes two flip-flops, so each reaction lags about three clocks.
// The link needs at least four clocks per half period of its serial clock.
// Settings move one clock after the link reports a whole frame.
// A cut or overlong frame still acknowledges, but changes no setting.
// The answer word is frozen at select fall; later closures wait a frame.
// Interrupt set beats acknowledge in one cycle, so no change is lost.
// A change seen while selected keeps the interrupt through that frame.
// Mode arrives as a plain input; sleep sequencing lives elsewhere.
// Overheat derates outputs only; the programmed bits are kept,
// so the old currents return by themselves once the die cools.
// Heat outside Normal mode is ignored, as the monitor rests there;
// a die already hot when Normal mode returns raises no interrupt.
// Analog code 0 and codes past the last input select nothing.
// Analog mode 3 is taken as a low current source, the safe choice.
// The wetting window restarts on each closure edge and dies on opening.
// Window length is a parameter so a bench can shorten it.
// Sources are computed from next settings, so a command and its
// effect land in the same clock and no one-clock glitch appears.
// Trade-off: every input carries its own window counter, which costs
// area but lets closures on different inputs overlap freely.
module swc_channel_ctrl
   import swc_pkg::*;
#(
   parameter int WET_CNT = WET_CYCLES // Wetting window length in clocks
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output logic so_out,
   output logic so_oe_n,
   input wire logic [swc_pkg::N_IN-1:0] term_high,
   input wire logic over_temp,
   input wire logic normal_mode,
   output logic [swc_pkg::N_IN-1:0] src_on,
   output logic [swc_pkg::N_IN-1:0] src_high,
   output logic [swc_pkg::N_SP-1:0] sp_sink,
   output logic [swc_pkg::ANA_CODE_W-1:0] analog_mux_output_sel,
   output logic int_n
);
   import swc_pkg::*;

   // All state of the block
   typedef struct packed {
      logic [N_IN-1:0] tri_st; // 1 = input tri-stated
      logic [N_IN-1:0] metal; // 1 = high current contact type
      logic [N_IN-1:0] wet_en; // 1 = wetting timer in use
      logic [N_IN-1:0] int_en; // 1 = changes raise interrupt
      logic [N_SP-1:0] sp_batt; // 1 = switch to battery
      logic [ANA_CODE_W-1:0] ana_code; // Active analog channel code
      logic [ANA_MODE_W-1:0] ana_mode; // Analog current mode
      logic [N_IN-1:0] lvl_s1; // Terminal sync, first stage
      logic [N_IN-1:0] lvl_s2; // Terminal sync, second stage
      logic hot_s1; // Thermal sync, first stage
      logic hot_s2; // Thermal sync, second stage
      logic hot_d; // Thermal level last cycle
      logic [N_IN-1:0] closed_d; // Closure state last cycle
      logic int_pend; // Interrupt waiting for acknowledge
      logic chg_in_frame; // Event seen while selected
      logic in_frame; // Select is low
      logic therm_flag; // Sticky overheat flag
      logic [N_IN-1:0] src_on; // Registered source enables
      logic [N_IN-1:0] src_high; // Registered high current selects
      logic [N_SP-1:0] sp_sink; // Registered sink directions
   } swc_st_t;

   swc_st_t st;
   swc_st_t next_st;

   // Link and timer wiring
   logic frame_start;
   logic frame_end;
   logic frame_ok;
   logic [FRAME_BITS-1:0] rx_word;
   logic [FRAME_BITS-1:0] tx_word;
   logic [N_IN-1:0] closed; // Switch closed per input
   logic [N_IN-1:0] window; // Wetting window open per input
   logic [N_IN-1:0] ana_sel; // One-hot analog selection
   logic [N_IN-1:0] status; // Reported status bits

   // One-hot input mask for an analog code; code 0 selects nothing
   function automatic logic [N_IN-1:0] swc_ana_mask(input logic [ANA_CODE_W-1:0] code);
      logic [N_IN-1:0] m;
      m = '0;
      for (int i = 0; i < N_IN; i++) begin
         if (code == ANA_CODE_W'(i + 1)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // Serial link with its own pin synchronisers
   swc_spi_link u_link (
      .clk(clk),
      .rst_n(rst_n),
      .sclk(sclk),
      .cs_n(cs_n),
      .si(si),
      .tx_word(tx_word),
      .frame_start(frame_start),
      .frame_end(frame_end),
      .frame_ok(frame_ok),
      .rx_word(rx_word),
      .so_out(so_out),
      .so_oe_n(so_oe_n)
   );

   // Wetting windows run off closure edges
   swc_wet_timer #(
      .CYCLES(WET_CNT)
   ) u_wet (
      .clk(clk),
      .rst_n(rst_n),
      .closed(closed),
      .window(window)
   );

   // Closure per input from the synced terminal level
   always_comb begin
      // Ground inputs close towards ground
      for (int i = 0; i < N_SG; i++) begin
         closed[i] = ~st.lvl_s2[i]; // RULE10
      end
      // Programmable inputs follow their direction bit
      for (int j = 0; j < N_SP; j++) begin
         if (st.sp_batt[j]) begin
            closed[N_SG+j] = st.lvl_s2[N_SG+j]; // Battery switch pulls high
         end else begin
            closed[N_SG+j] = ~st.lvl_s2[N_SG+j]; // RULE10
         end
      end
   end

   // Comparator keeps reading even when tri-stated; analog input reads 0
   assign ana_sel = swc_ana_mask(st.ana_code);
   assign status = closed & ~ana_sel; // RULE6 RULE10

   // Answer word loaded when select falls
   assign tx_word = {st.therm_flag, st.int_pend, status};

   // Next state: sync, command decode, sources, events
   always_comb begin
      logic [OP_W-1:0] op;
      logic [15:0] data;
      logic is_sp;
      logic [N_IN-1:0] chg;
      logic ev;
      logic ack;
      logic hot; // Overheat that counts: Normal mode only
      logic [N_IN-1:0] next_ana; // Analog mask of the next code
      // Give every local a value before any branch reads it
      chg = '0;
      ev = 1'b0;
      ack = 1'b0;
      hot = st.hot_s2 && normal_mode; // RULE15
      next_ana = '0;
      op = rx_word[OP_LSB +: OP_W];
      data = rx_word[15:0];
      is_sp = op[0];
      next_st = st;

      // Two-stage synchronisers for pins from outside the clock domain
      next_st.lvl_s1 = term_high;
      next_st.lvl_s2 = st.lvl_s1;
      next_st.hot_s1 = over_temp;
      next_st.hot_s2 = st.hot_s1;
      next_st.hot_d = st.hot_s2;
      next_st.closed_d = closed;

      // Frame tracking
      if (frame_start) begin
         next_st.in_frame = 1'b1;
      end else if (frame_end) begin
         next_st.in_frame = 1'b0;
      end

      // Commands apply only at the end of a whole frame in Normal mode
      if (frame_ok && normal_mode) begin // RULE14 RULE17
         case (op)
            OP_SETTINGS_SP: begin
               // Direction bits, programmable bank only
               next_st.sp_batt = data[N_SP-1:0]; // RULE9
            end
            OP_METAL_SG, OP_METAL_SP: begin
               // Contact type per bank, 1 picks the high current
               next_st.metal = swc_merge(st.metal, data, is_sp); // RULE3
            end
            OP_WETTMR_SG, OP_WETTMR_SP: begin
               // Timer enables per bank
               next_st.wet_en = swc_merge(st.wet_en, data, is_sp); // RULE2
            end
            OP_TRI_SG, OP_TRI_SP: begin
               // Tri-state per bank, 1 turns the source off
               next_st.tri_st = swc_merge(st.tri_st, data, is_sp); // RULE11
            end
            OP_INTEN_SG, OP_INTEN_SP: begin
               // Interrupt enables per bank
               next_st.int_en = swc_merge(st.int_en, data, is_sp); // RULE12
            end
            OP_ANALOG: begin
               // Codes beyond the last input select nothing
               if (data[ANA_CODE_W-1:0] <= ANA_CODE_W'(N_IN)) begin
                  next_st.ana_code = data[ANA_CODE_W-1:0]; // RULE4 RULE5
               end else begin
                  next_st.ana_code = ANA_NONE;
               end
               next_st.ana_mode = data[ANA_MODE_LSB +: ANA_MODE_W]; // RULE7
            end
            default: begin
               // Unknown code: nothing changes
            end
         endcase
      end

      // Events: enabled state changes and overheat onset
      chg = (closed ^ st.closed_d) & st.int_en; // RULE12
      ev = (|chg) || (hot && !st.hot_d); // RULE15
      // Acknowledge only a frame that saw no change of its own
      ack = frame_end && !st.chg_in_frame && !ev;

      // Event during a frame blocks that frame's acknowledge
      if (frame_start) begin
         next_st.chg_in_frame = ev;
      end else if (st.in_frame && ev) begin
         next_st.chg_in_frame = 1'b1;
      end

      // Set wins over acknowledge
      next_st.int_pend = ev | (st.int_pend & ~ack); // RULE16

      // Thermal flag clears at frame end only once cool; a frame that
      // ends while still hot leaves it set for the next answer word
      if (hot) begin
         next_st.therm_flag = 1'b1; // RULE15
      end else if (frame_end) begin
         next_st.therm_flag = 1'b0;
      end

      // Current sources, computed from the next settings so that they
      // move in the same clock as the command that changes them
      next_ana = swc_ana_mask(next_st.ana_code); // RULE5
      for (int i = 0; i < N_IN; i++) begin
         if (next_ana[i]) begin
            // Analog channel uses its own current mode
            next_st.src_on[i] = (next_st.ana_mode != ANA_HIZ); // RULE7
            next_st.src_high[i] = (next_st.ana_mode == ANA_HIGH) && !hot; // RULE7 RULE15
         end else begin
            // Tri-state bit gates the programmed source
            next_st.src_on[i] = ~next_st.tri_st[i]; // RULE11
            // High current while window open, or always when timer off
            next_st.src_high[i] = next_st.metal[i] && !hot &&
                                  (!next_st.wet_en[i] || window[i]); // RULE1 RULE2 RULE3 RULE15
         end
      end
      next_st.sp_sink = next_st.sp_batt; // RULE9
   end

   // State register; reset leaves every input tri-stated
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
         st.tri_st <= RST_TRI; // RULE8
         st.metal <= RST_METAL;
         st.wet_en <= RST_WET_EN;
         st.int_en <= RST_INT_EN;
         st.sp_batt <= RST_SP_BATT;
         st.ana_code <= ANA_NONE;
         st.ana_mode <= ANA_HIZ;
         // Syncs start at the open level so no closure is seen after reset
         st.lvl_s1 <= '1;
         st.lvl_s2 <= '1;
         st.closed_d <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign src_on = st.src_on;
   assign src_high = st.src_high;
   assign sp_sink = st.sp_sink;
   assign analog_mux_output_sel = st.ana_code; // RULE5
   assign int_n = ~st.int_pend; // RULE16

endmodule // swc_channel_ctrl

// File: rtl/swc_pkg.sv
// Shared constants, command codes and helpers for the switch input channel control
package swc_pkg;

   // Input counts: ground-only inputs first, then programmable ones
   localparam int N_SG = 14;
   localparam int N_SP = 8;
   localparam int N_IN = N_SG + N_SP;

   // Serial frame layout
   localparam int FRAME_BITS = 24;
   localparam int BCNT_W = 5;
   localparam logic [BCNT_W-1:0] BCNT_FULL = 5'h18;
   localparam logic [BCNT_W-1:0] BCNT_MAX = 5'h1F;
   localparam int OP_LSB = 16;
   localparam int OP_W = 8;
   localparam int SO_THERM_BIT = 23;
   localparam int SO_INT_BIT = 22;

   // Command codes in frame bits 23:16
   localparam logic [OP_W-1:0] OP_SETTINGS_SP = 8'h01;
   localparam logic [OP_W-1:0] OP_METAL_SG = 8'h02;
   localparam logic [OP_W-1:0] OP_METAL_SP = 8'h03;
   localparam logic [OP_W-1:0] OP_WETTMR_SG = 8'h04;
   localparam logic [OP_W-1:0] OP_WETTMR_SP = 8'h05;
   localparam logic [OP_W-1:0] OP_TRI_SG = 8'h06;
   localparam logic [OP_W-1:0] OP_TRI_SP = 8'h07;
   localparam logic [OP_W-1:0] OP_INTEN_SG = 8'h08;
   localparam logic [OP_W-1:0] OP_INTEN_SP = 8'h09;
   localparam logic [OP_W-1:0] OP_ANALOG = 8'h0A;

   // Analog command fields
   localparam int ANA_CODE_W = 5;
   localparam int ANA_MODE_LSB = 5;
   localparam int ANA_MODE_W = 2;
   localparam logic [ANA_CODE_W-1:0] ANA_NONE = 5'h00;
   localparam logic [ANA_MODE_W-1:0] ANA_HIZ = 2'h0;
   localparam logic [ANA_MODE_W-1:0] ANA_LOW = 2'h1;
   localparam logic [ANA_MODE_W-1:0] ANA_HIGH = 2'h2;

   // Wetting window timing
   localparam longint CLK_HZ = 10000000;
   localparam longint WET_TIME_MS = 20;
   localparam int WET_CYCLES = int'((CLK_HZ * WET_TIME_MS) / 1000);
   localparam int WET_W = 18;

   // Reset values: all inputs tri-stated, low current, timers on, interrupts on
   localparam logic [N_IN-1:0] RST_TRI = 22'h3FFFFF;
   localparam logic [N_IN-1:0] RST_METAL = 22'h000000;
   localparam logic [N_IN-1:0] RST_WET_EN = 22'h3FFFFF;
   localparam logic [N_IN-1:0] RST_INT_EN = 22'h3FFFFF;
   localparam logic [N_SP-1:0] RST_SP_BATT = 8'h00;

   // Write one bank of a per-input vector, keep the other bank
   function automatic logic [N_IN-1:0] swc_merge(input logic [N_IN-1:0] old,
                                                 input logic [15:0] data,
                                                 input logic is_sp);
      logic [N_IN-1:0] r;
      r = old;
      if (is_sp) begin
         r[N_IN-1:N_SG] = data[N_SP-1:0];
      end else begin
         r[N_SG-1:0] = data[N_SG-1:0];
      end
      return r;
   endfunction

endpackage : swc_pkg

// File: rtl/swc_spi_link.sv
// Serial slave link: pin synchronisers, shifter and frame framing
module swc_spi_link
   import swc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic [swc_pkg::FRAME_BITS-1:0] tx_word,
   output logic frame_start,
   output logic frame_end,
   output logic frame_ok,
   output logic [swc_pkg::FRAME_BITS-1:0] rx_word,
   output logic so_out,
   output logic so_oe_n
);
   import swc_pkg::*;

   typedef struct packed {
      logic [2:0] s1; // First sync stage {sclk, cs_n, si}
      logic [2:0] s2; // Second sync stage
      logic sclk_d; // Previous synced clock
      logic cs_d; // Previous synced select
      logic [FRAME_BITS-1:0] rx; // Receive shifter
      logic [FRAME_BITS-1:0] tx; // Transmit shifter
      logic [BCNT_W-1:0] bcnt; // Bits seen, saturating
      logic so; // Serial out bit
      logic start; // Frame start pulse
      logic fin; // Frame end pulse
      logic ok; // Frame had exactly one word
   } swc_sl_t;

   swc_sl_t st;
   swc_sl_t next_st;

   // Mode 0: sample on rising clock, shift out on falling clock
   always_comb begin
      next_st = st;
      next_st.s1 = {sclk, cs_n, si};
      next_st.s2 = st.s1;
      next_st.sclk_d = st.s2[2];
      next_st.cs_d = st.s2[1];
      next_st.start = 1'b0;
      next_st.fin = 1'b0;
      if (st.cs_d && !st.s2[1]) begin
         next_st.tx = tx_word;
         next_st.so = tx_word[FRAME_BITS-1];
         next_st.bcnt = '0;
         next_st.start = 1'b1;
      end else if (!st.cs_d && st.s2[1]) begin
         next_st.fin = 1'b1;
         next_st.ok = (st.bcnt == BCNT_FULL); // RULE17
      end else if (!st.s2[1]) begin
         if (!st.sclk_d && st.s2[2]) begin
            next_st.rx = {st.rx[FRAME_BITS-2:0], st.s2[0]};
            if (st.bcnt != BCNT_MAX) begin
               next_st.bcnt = st.bcnt + 1'b1;
            end
         end else if (st.sclk_d && !st.s2[2]) begin
            next_st.tx = {st.tx[FRAME_BITS-2:0], 1'b0};
            next_st.so = st.tx[FRAME_BITS-2];
         end
      end
   end

   // State register; select idles high so no false edge after reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
         st.s1 <= 3'h2;
         st.s2 <= 3'h2;
         st.cs_d <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign frame_start = st.start;
   assign frame_end = st.fin;
   assign frame_ok = st.fin & st.ok;
   assign rx_word = st.rx;
   assign so_out = st.so;
   assign so_oe_n = st.cs_d; // Drive only while selected

endmodule // swc_spi_link

// File: rtl/swc_wet_timer.sv
// Per-input wetting window timers started by each switch closure
module swc_wet_timer
   import swc_pkg::*;
#(
   parameter int CYCLES = WET_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [swc_pkg::N_IN-1:0] closed,
   output logic [swc_pkg::N_IN-1:0] window
);
   import swc_pkg::*;

   // Last count value, cast to WET_W bits with no check, so CYCLES must fit WET_W bits
   localparam logic [WET_W-1:0] LAST = WET_W'(CYCLES - 1);

   typedef struct packed {
      logic [N_IN-1:0][WET_W-1:0] cnt; // Cycles since closure
      logic [N_IN-1:0] prev; // Closure state last cycle
      logic [N_IN-1:0] win; // Window open
   } swc_wt_t;

   swc_wt_t st;
   swc_wt_t next_st;

   // Open on closure edge, close after CYCLES or on opening
   always_comb begin
      next_st = st;
      next_st.prev = closed;
      for (int i = 0; i < N_IN; i++) begin
         if (closed[i] && !st.prev[i]) begin
            next_st.win[i] = 1'b1; // RULE1
            next_st.cnt[i] = '0;
         end else if (!closed[i]) begin
            next_st.win[i] = 1'b0;
         end else if (st.win[i]) begin
            if (st.cnt[i] == LAST) begin
               next_st.win[i] = 1'b0; // RULE1
            end else begin
               next_st.cnt[i] = st.cnt[i] + 1'b1;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign window = st.win;

endmodule // swc_wet_timer

// File: verif/swc_channel_ctrl_props.sv
// Port checker for the switch input channel control, bound to the top module
module swc_channel_ctrl_props
   import swc_pkg::*;
#(
   parameter int WET_CNT = WET_CYCLES // Passed on for symmetry with the design
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic so_oe_n,
   input wire logic over_temp,
   input wire logic normal_mode,
   input wire logic [swc_pkg::N_IN-1:0] src_on,
   input wire logic [swc_pkg::N_IN-1:0] src_high,
   input wire logic [swc_pkg::N_SP-1:0] sp_sink,
   input wire logic [swc_pkg::ANA_CODE_W-1:0] analog_mux_output_sel,
   input wire logic int_n
);
   // Single clock domain, reset gates everything but the reset check
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Reset must leave every source off and the mux idle
   AST_RESET_VALS: assert property (disable iff (1'b0)
      !rst_n |=> src_on == '0 && src_high == '0 && sp_sink == '0 && analog_mux_output_sel == '0 && int_n)
      else $error("outputs not at reset values");
   AST_ANALOG_MUX_OUTPUT_RANGE: assert property (
      analog_mux_output_sel <= 5'h16)
      else $error("analog code out of range");
   // Mux moves only once select has been high for a while
   AST_ANALOG_MUX_OUTPUT_AT_CS: assert property (
      $changed(analog_mux_output_sel) |-> cs_n && $past(cs_n, 3))
      else $error("analog select changed inside a frame");
   // Settings frozen while a frame is in flight
   AST_CFG_HOLD: assert property (
      !cs_n |=> $stable(src_on) && $stable(sp_sink) && $stable(analog_mux_output_sel))
      else $error("settings changed while selected");
   AST_HOT_LOW: assert property (
      (over_temp && normal_mode) [*6] |-> src_high == '0)
      else $error("high current kept while hot");
   AST_HOT_INT: assert property (
      $rose(over_temp) ##0 normal_mode [*4] |-> ##[0:3] !int_n)
      else $error("no interrupt on overheat");
   // Only a frame end may release the interrupt
   AST_INT_HOLD: assert property (
      cs_n [*8] ##0 !int_n |=> !int_n)
      else $error("interrupt released without a frame");
   AST_SO_ON: assert property (
      $fell(cs_n) |-> ##[1:5] !so_oe_n)
      else $error("serial out not enabled");
   AST_SO_OFF: assert property (
      cs_n [*6] |-> so_oe_n)
      else $error("serial out driven while idle");
endmodule // swc_channel_ctrl_props

bind swc_channel_ctrl swc_channel_ctrl_props #(.WET_CNT(WET_CNT)) u_props (
   .clk(clk),
   .rst_n(rst_n),
   .cs_n(cs_n),
   .so_oe_n(so_oe_n),
   .over_temp(over_temp),
   .normal_mode(normal_mode),
   .src_on(src_on),
   .src_high(src_high),
   .sp_sink(sp_sink),
   .analog_mux_output_sel(analog_mux_output_sel),
   .int_n(int_n)
);

// File: verif/swc_channel_ctrl_tb_top.sv
// Self-checking bench for the switch input channel control
module swc_channel_ctrl_tb_top
   import swc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'b0; // 10 MHz system clock
   logic rst_n = 1'b0;
   logic sclk, cs_n, si, so_out, so_oe_n, int_n, over_temp, normal_mode;
   logic [N_IN-1:0] term_high, src_on, src_high;
   logic [N_SP-1:0] sp_sink;
   logic [ANA_CODE_W-1:0] analog_mux_output_sel;
   logic [23:0] rx; // Last word read back
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;

   // Short wetting window keeps the run brief
   swc_channel_ctrl #(.WET_CNT(20)) uut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .si(si), .so_out(so_out), .so_oe_n(so_oe_n), .term_high(term_high),
      .over_temp(over_temp), .normal_mode(normal_mode), .src_on(src_on),
      .src_high(src_high), .sp_sink(sp_sink), .analog_mux_output_sel(analog_mux_output_sel), .int_n(int_n));

   swc_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out));

   initial begin
      forever #50 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmd(input logic [7:0] op, input logic [15:0] d);
      host.xfer({op, d}, 24, rx);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      term_high = '1; // All switches open
      over_temp = 1'b0;
      normal_mode = 1'b1;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      chk("reset", 24'h000003, {src_on, int_n, so_oe_n});
      chk("reset_sink", 24'h0, 24'(sp_sink));
      chk("reset_hi", 24'h0, {src_high, analog_mux_output_sel == 5'h00, 1'b0} ^ 24'h2);
      host.xfer(24'h0, 24, rx);
      cmd(OP_TRI_SG, 16'h3FFE);
      chk("src_on", 24'h1, 24'(src_on));
      cmd(OP_METAL_SG, 16'h0001);
      chk("src_high_open", 24'h0, 24'(src_high));
      // Close an active input and a tri-stated one
      term_high[0] = 1'b0;
      term_high[5] = 1'b0;
      repeat (6) @(negedge clk);
      chk("src_high_wet", 24'h1, 24'(src_high));
      chk("int_n_set", 24'h0, 24'(int_n));
      repeat (24) @(negedge clk);
      chk("src_high_end", 24'h0, 24'(src_high));
      chk("int_n_held", 24'h0, 24'(int_n));
      host.xfer(24'h0, 24, rx);
      chk("status", 24'h400021, rx);
      chk("int_n_ack", 24'h1, 24'(int_n));
      cmd(OP_WETTMR_SG, 16'h3FFE);
      chk("src_high_cont", 24'h1, 24'(src_high));
      cmd(OP_WETTMR_SG, 16'h3FFF);
      chk("src_high_timed", 24'h0, 24'(src_high));
      // Masked input stays silent, unmasked one interrupts
      cmd(OP_INTEN_SG, 16'h3FFD);
      term_high[1] = 1'b0;
      repeat (10) @(negedge clk);
      chk("int_masked", 24'h1, 24'(int_n));
      term_high[3] = 1'b0;
      repeat (10) @(negedge clk);
      chk("int_unmasked", 24'h0, 24'(int_n));
      // Cut-short frame and a frame outside Normal mode change nothing
      host.xfer({OP_TRI_SG, 16'h3FFF}, 23, rx);
      chk("partial", 24'h1, 24'(src_on));
      normal_mode = 1'b0;
      cmd(OP_TRI_SG, 16'h3FFF);
      chk("not_normal", 24'h1, 24'(src_on));
      normal_mode = 1'b1;
      // Gate driver setup on the first programmable input
      cmd(OP_WETTMR_SP, 16'h00FE);
      cmd(OP_METAL_SP, 16'h0001);
      cmd(OP_SETTINGS_SP, 16'h0001);
      cmd(OP_TRI_SP, 16'h00FE);
      chk("sp_sink", 24'h1, 24'(sp_sink));
      chk("sp_src", 24'h004001, 24'(src_on));
      chk("sp_high", 24'h004000, 24'(src_high));
      cmd(OP_SETTINGS_SP, 16'h0000);
      chk("sp_source", 24'h0, 24'(sp_sink));
      host.xfer(24'h0, 24, rx);
      chk("int_clear", 24'h1, 24'(int_n));
      // Overheat drops high current and restores it after cooling
      over_temp = 1'b1;
      repeat (8) @(negedge clk);
      chk("hot_high", 24'h0, 24'(src_high));
      chk("hot_int", 24'h0, 24'(int_n));
      over_temp = 1'b0;
      repeat (8) @(negedge clk);
      chk("cool_high", 24'h004000, 24'(src_high));
      host.xfer(24'h0, 24, rx);
      chk("therm_flag", 24'h1, 24'(rx[23]));
      // Analog select on input 5 in each source mode
      for (int m = 0; m < 3; m++) begin
         cmd(OP_ANALOG, {9'h000, 2'(m), 5'h06});
         chk("analog_mux_output_sel", 24'h6, 24'(analog_mux_output_sel));
         chk("ana_src", {22'h0, m != 0, m == 2}, {22'h0, src_on[5], src_high[5]});
         host.xfer(24'h0, 24, rx);
         chk("ana_status", 24'h0, 24'(rx[5]));
      end
      cmd(OP_ANALOG, 16'h0016);
      chk("analog_mux_output_top", 24'h16, 24'(analog_mux_output_sel));
      cmd(OP_ANALOG, 16'h0017);
      chk("analog_mux_output_over", 24'h0, 24'(analog_mux_output_sel));
      tally_and_finish();
   end
endmodule // swc_channel_ctrl_tb_top

// File: verif/swc_host_model.sv
// Host controller model: serial master in mode 0, MSB first
module swc_host_model (
   input wire logic clk,
   output logic sclk,
   output logic cs_n,
   output logic si,
   input wire logic so_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle: deselected, serial clock parked low
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // One frame of n bits; half period of 4 clocks, 400 ns, gives an 800 ns period
   task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
      r = '0;
      @(negedge clk);
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         si = w[23-i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         r = {r[22:0], so_out};
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      // Released data line must not look like a held bit
      si = ~si;
      repeat (8) @(negedge clk);
   endtask
endmodule // swc_host_model
